// File: logic/countdown_guard_pkg.sv
/*
  package for the countdown guard: register map, field positions, reset values, timing counts.
  assumes a 125 MHz core clock and an APB register bus with 32-bit data.
*/
package countdown_guard_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] guard_control_reg_addr = 8'h14;
  localparam logic [7:0] misc_control_three_addr = 8'h4C;
  localparam logic [7:0] guard_status_addr = 8'h50;
  localparam int arm_bit_pos = 7;
  localparam int counter_top_bit_pos = 6;
  localparam int halt_permit_bit_pos = 7;
  localparam logic [7:0] guard_control_reset = 8'h7F;
  localparam logic [6:0] counter_reset = 7'h7F;
  localparam logic [7:0] misc_control_three_reset = 8'h00;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int clk_period_ns = 8;
  localparam int tick_cycles_default = 65536;
  localparam int wake_delay_cycles = 514;
  localparam int reset_pulse_ns = 500;
  localparam int reset_pulse_cycles = (reset_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int prescale_width = 17;
  localparam int wake_width = 10;
  localparam int pulse_width = 7;

  // state of the halt / wake sequence
  typedef enum logic [2:0] {
    st_run  = 3'b001,
    st_halt = 3'b010,
    st_wake = 3'b100
  } halt_state_e;

  function automatic logic top_bit_falls(input logic [6:0] old_val, input logic [6:0] new_val);
    top_bit_falls = old_val[counter_top_bit_pos] && !new_val[counter_top_bit_pos];
  endfunction
endpackage

// File: logic/countdown_watchdog.sv
/*
  countdown watchdog: 7-bit free-running down counter behind an APB slave, with
  software or hardware arming, halt and wake handling and a stretched reset pulse.
  assumes the system resets this block through reset_in when reset_n_out falls,
  and that halt, wake and suspend indications come from pins of other domains.
*/
// The APB slave port is this design's own decision.
//
// Function
// R1 - in the software variant the guard leaves every reset disarmed and once armed only a reset disarms it.
// R2 - one write that sets the arm bit and clears the counter top bit resets the device at once; here only if the counter top bit was already set.
// R3 - in the hardware variant the guard is always active and the arm bit has no effect.
// R4 - wait mode leaves counting and reset generation unchanged.
// R5 - with halt permitted, halt is entered and the stopped guard neither counts nor resets until wake or reset.
// R6 - after a wake from halt the counter resumes only after 514 clock cycles.
// R7 - in usb suspend, entering halt never causes a guard reset.
// R8 - the arm bit is set by software, cleared only by reset, and gates every guard reset in the software variant.
// R9 - the counter holds the decremented value and a fall of its top bit (40h to 3Fh) triggers a reset.
// R10 - the control register resets to 7Fh.
// R11 - the control register sits at 14h with the arm bit at bit 7 and the counter in bits 6:0.
// R12 - software should reload the counter just before halting to avoid a reset after wake.
// R13 - the counter decrements every 65536 cycles, even while disarmed.
// R14 - a guard reset drives the reset pin low for about 500 ns.
// R15 - with halt not permitted and the guard active, a halt resets the device unless usb is suspended.
// R16 - a control write loads the counter directly and a zero arm bit leaves an armed guard armed.
`timescale 1ns/1ns
module countdown_watchdog
  import countdown_guard_pkg::*;
#(
  parameter int tick_cycles = tick_cycles_default
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic hardware_variant_in,
  input wire logic wait_mode_in,
  input wire logic halt_request_in,
  input wire logic wake_irq_in,
  input wire logic usb_suspend_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic halted_out,
  output logic reset_n_out
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic halt_sync;
  logic wake_sync;
  logic suspend_sync;
  logic hw_sync;
  logic wait_sync;

  guard_sync u_halt_sync (.clk_in(clk_in), .reset_in(reset_in), .async_in(halt_request_in), .sync_out(halt_sync));
  guard_sync u_wake_sync (.clk_in(clk_in), .reset_in(reset_in), .async_in(wake_irq_in), .sync_out(wake_sync));
  guard_sync u_susp_sync (.clk_in(clk_in), .reset_in(reset_in), .async_in(usb_suspend_in), .sync_out(suspend_sync));
  guard_sync u_hw_sync (.clk_in(clk_in), .reset_in(reset_in), .async_in(hardware_variant_in), .sync_out(hw_sync));
  guard_sync u_wait_sync (.clk_in(clk_in), .reset_in(reset_in), .async_in(wait_mode_in), .sync_out(wait_sync));

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic arm_bit;
  logic [6:0] counter;
  logic halt_permit_bit;
  logic hw_variant;
  logic hw_captured;
  logic [1:0] hw_settle;
  logic [prescale_width-1:0] prescale;
  logic [wake_width-1:0] wake_count;
  logic halt_seen;
  logic trigger;
  halt_state_e state;
  halt_state_e next_state;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire bus_access = psel_in && penable_in;
  wire hit_control = (paddr_in == guard_control_reg_addr);
  wire hit_misc = (paddr_in == misc_control_three_addr);
  wire hit_status = (paddr_in == guard_status_addr);
  wire addr_mapped = hit_control || hit_misc || hit_status;
  wire write_control = bus_access && pwrite_in && hit_control && clk_en_in;
  wire write_misc = bus_access && pwrite_in && hit_misc && clk_en_in;

  // wait mode does not feed the count; only an assertion watches it [R4]
  wire guard_active = hw_variant || arm_bit; // [R3] [R8]
  wire running = (state == st_run);
  wire tick = running && (prescale == prescale_width'(tick_cycles - 1)); // [R13]
  wire [6:0] decremented = counter - 7'h01;
  wire [6:0] next_counter = write_control ? pwdata_in[6:0] : (tick ? decremented : counter); // [R16] [R9]
  wire next_arm = write_control ? (arm_bit || pwdata_in[arm_bit_pos]) : arm_bit; // [R1] [R16]
  wire next_active = hw_variant || next_arm;
  wire halt_edge = halt_sync && !halt_seen;
  wire halt_reset = running && halt_edge && guard_active && !halt_permit_bit && !suspend_sync; // [R15] [R7]
  wire expiry = next_active && top_bit_falls(counter, next_counter); // [R9] [R2]
  wire next_trigger = clk_en_in && !trigger && (expiry || halt_reset);

  // ----------------------------------------------------------------------
  // halt and wake sequence
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (halt_edge && !halt_reset) begin
          next_state = st_halt; // [R5] [R7]
        end
      end
      st_halt: begin
        if (wake_sync) begin
          next_state = st_wake;
        end
      end
      st_wake: begin
        if (wake_count == wake_width'(wake_delay_cycles - 1)) begin
          next_state = st_run; // [R6]
        end
      end
      default: next_state = st_run;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= st_run;
      wake_count <= '0;
      halt_seen <= 1'b0;
    end else if (clk_en_in) begin
      state <= next_state;
      halt_seen <= halt_sync;
      wake_count <= (state == st_wake) ? wake_count + 1'b1 : '0; // [R6]
    end
  end

  // ----------------------------------------------------------------------
  // counter, prescaler and control bits
  // ----------------------------------------------------------------------
  // the variant strap is caught once after reset release, never under reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hw_variant <= 1'b0;
      hw_captured <= 1'b0;
      hw_settle <= 2'h0;
    end else if (clk_en_in && !hw_captured) begin
      hw_settle <= hw_settle + 2'h1;
      // the synchroniser shows zero for two edges after release, so let it fill first
      if (hw_settle == 2'h2) begin
        hw_variant <= hw_sync; // [R3]
        hw_captured <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      arm_bit <= guard_control_reset[arm_bit_pos]; // [R1] [R10]
      counter <= counter_reset; // [R10]
      halt_permit_bit <= misc_control_three_reset[halt_permit_bit_pos];
      prescale <= '0;
    end else if (clk_en_in) begin
      arm_bit <= next_arm; // [R8]
      counter <= next_counter;
      if (write_misc) begin
        halt_permit_bit <= pwdata_in[halt_permit_bit_pos];
      end
      // the prescaler stands still while the oscillator is halted [R5]
      if (running) begin
        prescale <= tick ? '0 : prescale + 1'b1; // [R13]
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      trigger <= 1'b0;
    end else begin
      trigger <= next_trigger;
    end
  end

  guard_pulse u_pulse (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .trigger_in(trigger),
    .reset_n_out(reset_n_out)
  );

  // ----------------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------------
  wire [7:0] control_view = {arm_bit, counter}; // [R11]
  wire [7:0] misc_view = {halt_permit_bit, 7'h00};
  wire [7:0] status_view = {5'h00, hw_variant, guard_active, !running};
  wire [7:0] read_view = hit_control ? control_view : (hit_misc ? misc_view : status_view);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= addr_mapped ? {24'h000000, read_view} : 32'h0000_0000;
    end
  end

  assign pready_out = clk_en_in;
  assign pslverr_out = bus_access && !addr_mapped;
  assign halted_out = !running;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_wake_start;
    (state == st_halt) && wake_sync && clk_en_in;
  endsequence

  property p_disarmed_after_reset;
    @(posedge clk_in) $fell(reset_in) |-> !arm_bit;
  endproperty
  a_disarmed_after_reset: assert property (p_disarmed_after_reset) else $error("arm bit set after reset"); // [R1]

  property p_arm_sticks;
    @(posedge clk_in) disable iff (reset_in) arm_bit |=> arm_bit;
  endproperty
  a_arm_sticks: assert property (p_arm_sticks) else $error("arm bit cleared without reset"); // [R1]

  property p_sw_reset;
    @(posedge clk_in) disable iff (reset_in)
      (write_control && pwdata_in[arm_bit_pos] && !pwdata_in[counter_top_bit_pos] && counter[6] && !trigger)
      |=> trigger ##1 !reset_n_out;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset not produced"); // [R2]

  property p_no_reset_inactive;
    @(posedge clk_in) disable iff (reset_in) (trigger && !halt_reset) |-> $past(next_active);
  endproperty
  a_no_reset_inactive: assert property (p_no_reset_inactive) else $error("reset while inactive"); // [R8]

  property p_halt_frozen;
    @(posedge clk_in) disable iff (reset_in) (state == st_halt && !write_control) |=> $stable(counter);
  endproperty
  a_halt_frozen: assert property (p_halt_frozen) else $error("counter moved during halt"); // [R5]

  property p_wake_delay;
    @(posedge clk_in) disable iff (reset_in) s_wake_start |=> (state == st_wake)[*8];
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("resumed too early after wake"); // [R6]

  property p_suspend_halt;
    @(posedge clk_in) disable iff (reset_in) (halt_edge && suspend_sync && running) |-> !halt_reset;
  endproperty
  a_suspend_halt: assert property (p_suspend_halt) else $error("halt reset in suspend"); // [R7]

  property p_pulse_low;
    @(posedge clk_in) disable iff (reset_in) $rose(trigger) |=> !reset_n_out[*8];
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("reset pulse too short"); // [R14]

  property p_wait_counts;
    @(posedge clk_in) disable iff (reset_in)
      (tick && wait_sync && clk_en_in && !write_control) |=> (counter == $past(counter) - 7'h01);
  endproperty
  a_wait_counts: assert property (p_wait_counts) else $error("count changed by wait mode"); // [R4]

  property p_disarmed_counts;
    @(posedge clk_in) disable iff (reset_in)
      (tick && !guard_active && clk_en_in && !write_control) |=> (counter != $past(counter));
  endproperty
  a_disarmed_counts: assert property (p_disarmed_counts) else $error("counter stopped while disarmed"); // [R13]

  // kept apart from wake_count, so the length check below does not just echo it
  logic [wake_width-1:0] wake_span;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wake_span <= '0;
    end else if (clk_en_in) begin
      wake_span <= (running || state == st_halt) ? '0 : wake_span + 1'b1;
    end
  end

  property p_wake_length;
    @(posedge clk_in) disable iff (reset_in)
      (state == st_wake && next_state == st_run && clk_en_in)
      |-> (wake_span == wake_width'(wake_delay_cycles - 1));
  endproperty
  a_wake_length: assert property (p_wake_length) else $error("wake delay length wrong"); // [R6]

  property p_permit_halt;
    @(posedge clk_in) disable iff (reset_in)
      (running && halt_edge && halt_permit_bit && clk_en_in) |=> (state == st_halt);
  endproperty
  a_permit_halt: assert property (p_permit_halt) else $error("halt refused with permit set"); // [R5]

  sequence s_halt_forbidden;
    running && halt_edge && guard_active && !halt_permit_bit && !suspend_sync && !trigger && clk_en_in;
  endsequence

  property p_halt_reset_fires;
    @(posedge clk_in) disable iff (reset_in) s_halt_forbidden |=> trigger ##1 !reset_n_out;
  endproperty
  a_halt_reset_fires: assert property (p_halt_reset_fires) else $error("halt did not reset"); // [R15]

  property p_arm_by_write;
    @(posedge clk_in) disable iff (reset_in) $rose(arm_bit) |-> $past(write_control);
  endproperty
  a_arm_by_write: assert property (p_arm_by_write) else $error("arm bit set without a write"); // [R8]
endmodule // countdown_watchdog

// File: logic/guard_pulse.sv
/*
  stretches a one-cycle trigger into a low-going reset pulse of a fixed length.
  assumes a single clock; runs regardless of clock enable so the pulse completes.
*/
`timescale 1ns/1ns
module guard_pulse
  import countdown_guard_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic trigger_in,
  output logic reset_n_out
);
  logic [pulse_width-1:0] remaining;
  wire pulse_active = (remaining != '0);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      remaining <= '0;
      reset_n_out <= 1'b1;
    end else begin
      if (trigger_in) begin
        remaining <= pulse_width'(reset_pulse_cycles); // [R14]
      end else if (pulse_active) begin
        remaining <= remaining - 1'b1;
      end
      reset_n_out <= !(trigger_in || (pulse_active && remaining != 1));
    end
  end
endmodule // guard_pulse

// File: logic/guard_sync.sv
/*
  two flip-flop synchroniser for one level.
  assumes the input is asynchronous to clk_in.
*/
`timescale 1ns/1ns
module guard_sync (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic async_in,
  output logic sync_out
);
  logic stage_one;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stage_one <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // guard_sync

// File: tb/countdown_watchdog_test.sv
/*
  self-checking bench for countdown_watchdog: apb master tasks, pulse monitor, halt and wake scenarios.
  assumes the design package is compiled first; tick_cycles is shortened to 16 to keep the run short.
*/
`timescale 1ns/1ns
module countdown_watchdog_test;
  import countdown_guard_pkg::*;
  localparam int tick = 16;
  logic clk_in, reset_in, clk_en, hw_variant, wait_mode, halt_req, wake_irq, suspend;
  logic psel, penable, pwrite, pready, pslverr, halted, reset_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int n_mismatch, n_compared, n_low, n_pulse, k, v;

  countdown_watchdog #(.tick_cycles(tick)) i_dut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en),
    .hardware_variant_in(hw_variant), .wait_mode_in(wait_mode), .halt_request_in(halt_req),
    .wake_irq_in(wake_irq), .usb_suspend_in(suspend), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .halted_out(halted), .reset_n_out(reset_n));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------------
  // wait mode toggles at random all run long; it must change nothing
  always @(posedge clk_in) wait_mode <= 1'($urandom);
  always @(posedge clk_in) if (reset_n === 1'b0) n_low <= n_low + 1;
  always @(negedge reset_n) n_pulse = n_pulse + 1;

  // ----------------------------------------------------------------------
  // reference model of the control register, in integers
  // ----------------------------------------------------------------------
  int m_arm, m_cnt, m_pre, m_rd;
  always @(posedge clk_in) begin
    if (reset_in) begin
      m_arm <= 0;
      m_cnt <= 127;
      m_pre <= 0;
    end else if (clk_en) begin
      m_pre <= (m_pre + 1) % tick;
      if (psel && penable && pwrite && paddr == guard_control_reg_addr) begin
        m_arm <= m_arm | int'(pwdata[7]);
        m_cnt <= int'(pwdata[6:0]);
      end else if (m_pre == tick - 1) begin
        m_cnt <= (m_cnt + 127) % 128;
      end
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // model value the slave latches for a read at this setup edge
    m_rd = m_arm * 128 + m_cnt;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    n_low = 0;
    n_pulse = 0;
  endtask

  // the expected number of guard resets, checked for the documented width when one is expected, then the system resets the block
  task automatic expect_pulse(input int cycles, input int exp_pulses);
    repeat (cycles) @(posedge clk_in);
    check(n_pulse, exp_pulses, "pulse count");
    if (exp_pulses > 0) check(n_low, reset_pulse_cycles, "pulse width");
    do_reset();
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    clk_en = 1'b1;
    hw_variant = 1'b0;
    halt_req = 1'b0;
    wake_irq = 1'b0;
    suspend = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_compared = 0;
    v = $urandom(32'h7F513ABC);
    do_reset();
    apb(1'b0, guard_control_reg_addr, 32'h0);
    check(rd, 32'h0000007F, "control reset value");
    check(rd, 32'(m_rd), "control against model");
    apb(1'b0, misc_control_three_addr, 32'h0);
    check(rd, 32'h00000000, "misc reset value");
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], err}, 32'h00000001, "unmapped read");
    $display("test registers done");
    // disarmed counter still runs and crosses its top bit without a reset
    v = 8'h48 + ($urandom % 56);
    apb(1'b1, guard_control_reg_addr, 32'(v));
    // clock enable low freezes the count and stalls the bus
    clk_en <= 1'b0;
    repeat (40) @(posedge clk_in);
    check(pready, 1'b0, "bus stall while disabled");
    clk_en <= 1'b1;
    repeat (5 * tick) @(posedge clk_in);
    apb(1'b0, guard_control_reg_addr, 32'h0);
    check(32'(rd[7:0] <= v - 4 && rd[7:0] >= v - 6), 32'h1, "free running count");
    check(rd, 32'(m_rd), "count against model");
    apb(1'b1, guard_control_reg_addr, 32'h00000041);
    repeat (4 * tick) @(posedge clk_in);
    expect_pulse(10, 0);
    $display("test disarmed done");
    apb(1'b1, guard_control_reg_addr, 32'h000000BF);
    expect_pulse(100, 1);
    apb(1'b0, guard_control_reg_addr, 32'h0);
    check(rd, 32'h0000007F, "disarmed after guard reset");
    check(rd, 32'(m_rd), "model after guard reset");
    $display("test forced reset done");
    // armed, then a write with arm clear still leaves the guard armed
    apb(1'b1, guard_control_reg_addr, 32'h000000C2);
    apb(1'b1, guard_control_reg_addr, 32'h00000042);
    expect_pulse(5 * tick + 80, 1);
    $display("test expiry done");
    hw_variant <= 1'b1;
    do_reset();
    apb(1'b1, guard_control_reg_addr, 32'h00000042);
    expect_pulse(5 * tick + 80, 1);
    hw_variant <= 1'b0;
    do_reset();
    $display("test hardware variant done");
    apb(1'b1, guard_control_reg_addr, 32'h000000FF);
    halt_req <= 1'b1;
    expect_pulse(100, 1);
    halt_req <= 1'b0;
    do_reset();
    $display("test halt reset done");
    suspend <= 1'b1;
    apb(1'b1, guard_control_reg_addr, 32'h000000FF);
    halt_req <= 1'b1;
    repeat (100) @(posedge clk_in);
    check(n_pulse, 0, "suspended halt");
    check(halted, 1'b1, "halted in suspend");
    halt_req <= 1'b0;
    suspend <= 1'b0;
    do_reset();
    $display("test suspend done");
    apb(1'b1, misc_control_three_addr, 32'h00000080);
    apb(1'b1, guard_control_reg_addr, 32'h000000C5);
    halt_req <= 1'b1;
    repeat (10 * tick) @(posedge clk_in);
    check(halted, 1'b1, "halted with permit");
    check(n_pulse, 0, "no reset while halted");
    apb(1'b0, guard_control_reg_addr, 32'h0);
    check(32'(rd[7:0] == 8'hC5 || rd[7:0] == 8'hC4), 32'h1, "counter frozen");
    wake_irq <= 1'b1;
    @(posedge clk_in);
    k = 0;
    while (halted === 1'b1 && k < 1000) begin
      @(posedge clk_in);
      k++;
    end
    check(32'(k >= wake_delay_cycles && k <= wake_delay_cycles + 6), 32'h1, "wake delay");
    wake_irq <= 1'b0;
    halt_req <= 1'b0;
    $display("test halt and wake done");
    complete_run();
  end
endmodule // countdown_watchdog_test
